// file: inc/hwrs_pkg.sv
// Notes on behaviour
// [R1] Power-down stops system oscillator; selected watchdog RC oscillator runs.
// [R2] During power-down memory, registers and port states stay unchanged.
// [R3] Power-down entry clears and restarts an RC-clocked watchdog.
// [R4] Power-down instruction sets power-down flag, clears timeout flag.
// [R5] Exit on external reset, interrupt, port fall or watchdog overflow.
// [R6] External reset ending power-down performs a complete initialization.
// [R7] Watchdog timeout in power-down zeroes only counter and stack pointer.
// [R8] Power-down flag cleared by power-up and watchdog clear.
// [R9] Timeout flag is set whenever a watchdog timeout occurs.
// [R10] First port bits wake individually; other ports wake as whole ports.
// [R11] A port wake resumes at the instruction after power-down.
// [R12] Interrupt wake resumes next if disabled or stack full, else vectors.
// [R13] An interrupt already pending at power-down entry cannot wake.
// [R14] Every wake inserts a dummy period of 1024 system clocks.
// [R15] Interrupt service starts at least one cycle after the dummy period.
// [R16] Reset sources: pin reset running, pin reset halted, watchdog running.
// [R17] Flags: 0,0 power-up or pin reset; 1,u watchdog; 1,1 watchdog wake.
// [R18] Start-up timer holds 1024 clocks after any chip reset.
// [R19] Chip reset clears counter, interrupts, watchdog, timers; ports input.
// [R20] Watchdog overflow when running gives chip reset and timeout flag.
// [R21] Start-up count runs on restarted oscillator; processor held till done.
// [R22] Port falls are seen while halted and restart the oscillator.
`default_nettype none
package hwrs_pkg;
  // -------------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] HWRS_OFS_CONFIG = 8'h00;
  localparam logic [7:0] HWRS_OFS_STATUS = 8'h04;
  localparam logic [7:0] HWRS_OFS_WDOG = 8'h08;
  // -------------------------------------------------------------------------
  // Configuration field positions
  // -------------------------------------------------------------------------
  localparam int HWRS_CFG_FIRST_MASK_LSB = 0;
  localparam int HWRS_CFG_SECOND_WAKE = 8;
  localparam int HWRS_CFG_THIRD_WAKE = 9;
  localparam int HWRS_CFG_FOURTH_WAKE = 10;
  localparam int HWRS_CFG_WDOG_ENABLE = 12;
  localparam int HWRS_CFG_WDOG_RC = 13;
  localparam int HWRS_CFG_RATIO_LSB = 16;
  localparam logic [31:0] HWRS_CONFIG_RESET = 32'h0007_3000;
  localparam logic [31:0] HWRS_CONFIG_WMASK = 32'h0007_37ff;
  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int HWRS_STARTUP_CYCLES = 1024;
  localparam int HWRS_INSTR_DIV = 4;
  localparam int HWRS_WDOG_BASE_BITS = 8;
  localparam logic [32:0] HWRS_PIN_RESET = 33'h1_ffff_ffff;
  typedef enum logic [1:0] {
    HWRS_ST_STARTUP,
    HWRS_ST_RUN,
    HWRS_ST_HALT,
    HWRS_ST_WAKE
  } hwrs_state_type;
endpackage
`default_nettype wire

// file: hdl/hwrs_sequencer.sv
// The APB slave port and the register addresses were chosen for this implementation.
`default_nettype none
module hwrs_sequencer
  import hwrs_pkg::*;
(
  input wire logic clk, // 50 MHz system clock
  input wire logic reset, // Power-on reset, synchronous, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address or on a write to a read-only register
  input wire logic external_reset_pin_n, // External reset pin, active low
  input wire logic [7:0] first_port, // First port pins
  input wire logic [7:0] second_port, // Second port pins
  input wire logic [7:0] third_port, // Third port pins
  input wire logic [7:0] fourth_port, // Fourth port pins
  input wire logic wdog_rc_clock, // Watchdog RC oscillator output
  input wire logic halt_instruction, // Core executes power-down, pulse
  input wire logic watchdog_clear_instruction, // Core clears watchdog, pulse
  input wire logic [2:0] irq_request, // Interrupt request flags
  input wire logic [2:0] irq_enable, // Per-source interrupt enables
  input wire logic irq_master_enable, // Global interrupt enable
  input wire logic stack_full, // Core stack is full
  output logic sys_osc_enable, // System oscillator runs
  output logic wdog_osc_enable, // Watchdog RC oscillator runs
  output logic cpu_clock_enable, // Processor may execute
  output logic chip_reset, // Full chip initialization, level
  output logic warm_reset, // Zero program counter and stack pointer, pulse
  output logic hold_ports, // Freeze port and register state
  output logic resume_next, // Continue after power-down instruction, pulse
  output logic resume_irq, // Take interrupt vector, pulse
  output logic power_down_flag, // Power-down flag
  output logic watchdog_timeout_flag // Watchdog timeout flag
);
  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  logic [32:0] pin_s1;
  logic [32:0] pin_s2;
  logic [32:0] pin_s3;
  logic [32:0] pin_stable;
  logic [32:0] pin_prev;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1 <= HWRS_PIN_RESET;
      pin_s2 <= HWRS_PIN_RESET;
      pin_s3 <= HWRS_PIN_RESET;
      pin_stable <= HWRS_PIN_RESET;
      pin_prev <= HWRS_PIN_RESET;
    end else begin
      pin_s1 <= {external_reset_pin_n, fourth_port, third_port,
                 second_port, first_port};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // A bit changes only once the two later stages agree.
      pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 ^ pin_s3));
      pin_prev <= pin_stable;
    end
  end

  logic ext_reset_active;
  logic [31:0] port_fall;
  assign ext_reset_active = ~pin_stable[32];
  assign port_fall = pin_prev[31:0] & ~pin_stable[31:0];

  // -------------------------------------------------------------------------
  // Configuration register
  // -------------------------------------------------------------------------
  logic [31:0] config_reg;
  logic bus_access;
  logic bus_write;
  assign bus_access = psel && penable && !pready;
  assign bus_write = bus_access && pwrite && (paddr == HWRS_OFS_CONFIG);

  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      config_reg <= HWRS_CONFIG_RESET;
    end else if (bus_write) begin
      config_reg <= pwdata & HWRS_CONFIG_WMASK;
    end
  end

  logic [7:0] first_mask;
  logic wdog_on;
  logic wdog_rc;
  logic [2:0] wdog_ratio;
  logic [31:0] wake_mask;
  assign first_mask = config_reg[HWRS_CFG_FIRST_MASK_LSB +: 8];
  assign wdog_on = config_reg[HWRS_CFG_WDOG_ENABLE];
  assign wdog_rc = config_reg[HWRS_CFG_WDOG_RC];
  assign wdog_ratio = config_reg[HWRS_CFG_RATIO_LSB +: 3];
  assign wake_mask = {{8{config_reg[HWRS_CFG_FOURTH_WAKE]}}, // R10
                      {8{config_reg[HWRS_CFG_THIRD_WAKE]}},
                      {8{config_reg[HWRS_CFG_SECOND_WAKE]}},
                      first_mask};

  // -------------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------------
  hwrs_state_type state;
  logic [10:0] delay_count;
  logic delay_done;
  logic wake_by_irq;
  logic wake_by_port;
  logic wake_warm;
  logic [2:0] irq_blocked;
  logic wdog_overflow;
  logic irq_wake;
  logic port_wake;
  logic service_irq;
  logic [1:0] instr_div;

  assign delay_done = (delay_count == 11'(HWRS_STARTUP_CYCLES - 1));
  assign irq_wake = |(irq_request & ~irq_blocked); // R13
  assign port_wake = |(port_fall & wake_mask); // R10 R22
  assign service_irq = irq_master_enable && !stack_full &&
                       |(irq_request & irq_enable); // R12

  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      state <= HWRS_ST_STARTUP; // R6 R16
    end else begin
      case (state)
        HWRS_ST_STARTUP: begin
          if (delay_done) begin
            state <= HWRS_ST_RUN; // R18
          end
        end
        HWRS_ST_RUN: begin
          if (wdog_overflow) begin
            state <= HWRS_ST_STARTUP; // R20
          end else if (halt_instruction) begin
            state <= HWRS_ST_HALT; // R1
          end
        end
        HWRS_ST_HALT: begin
          if (wdog_overflow || irq_wake || port_wake) begin
            state <= HWRS_ST_WAKE; // R5
          end
        end
        HWRS_ST_WAKE: begin
          if (delay_done) begin
            state <= HWRS_ST_RUN; // R14
          end
        end
        default: begin
          state <= HWRS_ST_STARTUP;
        end
      endcase
    end
  end

  // Count restarts on every entry to a delay state, on the running oscillator.
  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      delay_count <= 11'h000;
    end else if ((state == HWRS_ST_STARTUP || state == HWRS_ST_WAKE)
                 && !delay_done) begin
      delay_count <= delay_count + 11'h001; // R21
    end else begin
      delay_count <= 11'h000;
    end
  end

  // Pending requests at entry are remembered so they cannot wake the core.
  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      irq_blocked <= 3'h0;
    end else if (state == HWRS_ST_RUN && halt_instruction) begin
      irq_blocked <= irq_request; // R13
    end else if (state == HWRS_ST_HALT) begin
      irq_blocked <= irq_blocked & irq_request;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      wake_by_irq <= 1'b0;
      wake_by_port <= 1'b0;
      wake_warm <= 1'b0;
    end else if (state == HWRS_ST_HALT) begin
      wake_warm <= wdog_overflow; // R7
      wake_by_irq <= !wdog_overflow && irq_wake;
      wake_by_port <= !wdog_overflow && !irq_wake && port_wake;
    end
  end

  // -------------------------------------------------------------------------
  // Watchdog
  // -------------------------------------------------------------------------
  logic [14:0] wdog_count;
  logic wdog_tick;
  logic rc_s1;
  logic rc_s2;
  logic rc_s3;
  logic rc_stable;
  logic rc_edge;
  logic [14:0] wdog_limit;
  logic wdog_clear;
  assign wdog_limit = 15'((16'h0100 << wdog_ratio) - 16'h0001);
  assign wdog_clear = watchdog_clear_instruction ||
                      (state == HWRS_ST_RUN && halt_instruction); // R3
  // The instruction clock stops in power-down, so only RC mode guards halt.
  assign wdog_tick = wdog_rc ? rc_edge
                             : (state == HWRS_ST_RUN && instr_div == 2'h3);

  always_ff @(posedge clk) begin
    if (reset) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
      rc_stable <= 1'b0;
    end else begin
      rc_s1 <= wdog_rc_clock;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
      if (rc_s2 == rc_s3) begin
        rc_stable <= rc_s3;
      end
    end
  end
  assign rc_edge = (rc_s2 == rc_s3) && rc_s3 && !rc_stable;

  always_ff @(posedge clk) begin
    if (reset || state != HWRS_ST_RUN) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || ext_reset_active || wdog_clear || wdog_overflow ||
        state == HWRS_ST_STARTUP || !wdog_on) begin
      wdog_count <= 15'h0000; // R19
    end else if (wdog_tick && state != HWRS_ST_WAKE) begin
      wdog_count <= wdog_count + 15'h0001;
    end
  end
  assign wdog_overflow = wdog_on && wdog_tick && wdog_limit == wdog_count &&
                         (state == HWRS_ST_RUN || state == HWRS_ST_HALT);

  // -------------------------------------------------------------------------
  // Reset-cause flags
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      watchdog_timeout_flag <= 1'b0; // R17
    end else if (wdog_overflow) begin
      watchdog_timeout_flag <= 1'b1; // R9 R20
    end else if (state == HWRS_ST_RUN && halt_instruction) begin
      watchdog_timeout_flag <= 1'b0; // R4
    end else if (watchdog_clear_instruction) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || ext_reset_active) begin
      power_down_flag <= 1'b0; // R8 R17
    end else if (state == HWRS_ST_RUN && halt_instruction &&
                 !wdog_overflow) begin
      power_down_flag <= 1'b1; // R4
    end else if (watchdog_clear_instruction && state == HWRS_ST_RUN) begin
      power_down_flag <= 1'b0; // R8
    end
  end

  // -------------------------------------------------------------------------
  // Control outputs
  // -------------------------------------------------------------------------
  logic resume_pending;

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_osc_enable <= 1'b1;
      wdog_osc_enable <= 1'b0;
      cpu_clock_enable <= 1'b0;
      chip_reset <= 1'b1;
      warm_reset <= 1'b0;
      hold_ports <= 1'b0;
      resume_next <= 1'b0;
      resume_irq <= 1'b0;
      resume_pending <= 1'b0;
    end else begin
      // Port edges are sampled here while the oscillator model is stopped.
      sys_osc_enable <= (state != HWRS_ST_HALT) || port_wake ||
                        irq_wake || wdog_overflow; // R1 R22
      wdog_osc_enable <= wdog_on && wdog_rc; // R1
      cpu_clock_enable <= (state == HWRS_ST_RUN) && !halt_instruction &&
                          !wdog_overflow && !ext_reset_active; // R21
      chip_reset <= ext_reset_active || (state == HWRS_ST_STARTUP) ||
                    (state == HWRS_ST_RUN && wdog_overflow); // R19
      warm_reset <= (state == HWRS_ST_HALT) && wdog_overflow &&
                    !ext_reset_active; // R7
      hold_ports <= (state == HWRS_ST_HALT) ||
                    (state == HWRS_ST_RUN && halt_instruction); // R2
      resume_next <= (state == HWRS_ST_WAKE) && delay_done &&
                     !ext_reset_active &&
                     (wake_by_port || (wake_by_irq && !service_irq)); // R11
      // Vectoring waits a cycle past the dummy period.
      resume_pending <= (state == HWRS_ST_WAKE) && delay_done &&
                        !ext_reset_active && wake_by_irq && service_irq;
      resume_irq <= resume_pending; // R15
    end
  end

  // -------------------------------------------------------------------------
  // APB slave, one wait state on every access
  // -------------------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == HWRS_OFS_CONFIG) || (addr == HWRS_OFS_STATUS) ||
             (addr == HWRS_OFS_WDOG);
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (bus_access) begin
      pready <= 1'b1;
      pslverr <= !mapped(paddr) ||
                 (pwrite && paddr != HWRS_OFS_CONFIG);
      if (pwrite || !mapped(paddr)) begin
        prdata <= 32'h0000_0000;
      end else if (paddr == HWRS_OFS_CONFIG) begin
        prdata <= config_reg;
      end else if (paddr == HWRS_OFS_STATUS) begin
        prdata <= {24'h00_0000, wake_warm, wake_by_port, wake_by_irq,
                   1'b0, state, power_down_flag, watchdog_timeout_flag};
      end else begin
        prdata <= {17'h0_0000, wdog_count};
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // hwrs_sequencer
`default_nettype wire

// file: verification/hwrs_checker.sv
`default_nettype none
module hwrs_checker (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous reset
  input wire logic external_reset_pin_n, // reset pin, active low
  input wire logic halt_instruction, // power-down pulse
  input wire logic watchdog_clear_instruction, // watchdog clear pulse
  input wire logic irq_master_enable, // global interrupt enable
  input wire logic stack_full, // core stack full
  input wire logic sys_osc_enable, // system oscillator runs
  input wire logic cpu_clock_enable, // processor may execute
  input wire logic chip_reset, // full initialization
  input wire logic warm_reset, // counter and stack pointer reset
  input wire logic hold_ports, // state frozen
  input wire logic resume_irq, // vector taken
  input wire logic power_down_flag, // power-down flag
  input wire logic watchdog_timeout_flag // timeout flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Counts cycles with the oscillator running but the processor held, so a
  // start that comes too early is caught however the delay was entered.
  logic [11:0] settle;
  always_ff @(posedge clk) begin
    if (reset || cpu_clock_enable || !sys_osc_enable) begin
      settle <= 12'h000;
    end else if (settle != 12'hfff) begin
      settle <= settle + 12'h001;
    end
  end
  AST_HALT_ENTRY: assert property (
    halt_instruction && cpu_clock_enable |=> hold_ports && !cpu_clock_enable
      && power_down_flag && !watchdog_timeout_flag)
    else $error("halt entry outputs wrong");
  AST_OSC_STOP: assert property (
    halt_instruction && cpu_clock_enable |=> ##1 !sys_osc_enable)
    else $error("oscillator not stopped");
  AST_HOLD: assert property (hold_ports |-> !cpu_clock_enable)
    else $error("processor runs while frozen");
  AST_STARTUP: assert property (
    $rose(cpu_clock_enable) |-> settle >= 12'd1023)
    else $error("processor started before the delay");
  AST_WARM: assert property (
    warm_reset |-> !chip_reset ##[0:2]
      (watchdog_timeout_flag && power_down_flag))
    else $error("warm reset wrong");
  AST_PIN_RESET: assert property (
    !external_reset_pin_n [*7] |-> chip_reset && !cpu_clock_enable
      && !power_down_flag && !watchdog_timeout_flag)
    else $error("pin reset not applied");
  AST_WDOG_CLEAR: assert property (
    watchdog_clear_instruction && cpu_clock_enable |=> !power_down_flag)
    else $error("power-down flag not cleared");
  AST_IRQ_VECTOR: assert property (
    resume_irq |-> irq_master_enable && !stack_full)
    else $error("vector taken while not allowed");
endmodule // hwrs_checker
bind hwrs_sequencer hwrs_checker hwrs_checker_i (.clk, .reset,
  .external_reset_pin_n, .halt_instruction, .watchdog_clear_instruction,
  .irq_master_enable, .stack_full, .sys_osc_enable, .cpu_clock_enable,
  .chip_reset, .warm_reset, .hold_ports, .resume_irq, .power_down_flag,
  .watchdog_timeout_flag);
`default_nettype wire

// file: verification/hwrs_pin_model.sv
`default_nettype none
module hwrs_pin_model (
  input wire logic clk, // system clock
  output logic external_reset_pin_n, // reset pin, pulled high
  output logic [7:0] first_port, // first port pins
  output logic [7:0] second_port, // second port pins
  output logic [7:0] third_port, // third port pins
  output logic [7:0] fourth_port // fourth port pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // All pins have pull-ups, so a released pin always returns high.
  logic [31:0] pins = 32'hffff_ffff;
  assign {fourth_port, third_port, second_port, first_port} = pins;
  initial external_reset_pin_n = 1'b1;
  task automatic port_fall(input int idx, input logic [7:0] mask);
    @(posedge clk);
    pins[idx * 8 +: 8] <= ~mask;
    repeat (8) @(posedge clk);
    pins <= 32'hffff_ffff;
  endtask
  task automatic pin_reset(input int len);
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    repeat (len) @(posedge clk);
    external_reset_pin_n <= 1'b1;
  endtask
endmodule // hwrs_pin_model
`default_nettype wire

// file: verification/hwrs_sequencer_tb.sv
`default_nettype none
module hwrs_sequencer_tb import hwrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, stack_full;
  logic [7:0] paddr, first_port, second_port, third_port, fourth_port;
  logic [31:0] pwdata, prdata;
  logic external_reset_pin_n, wdog_rc_clock, rc_run, irq_master_enable;
  logic halt_instruction, watchdog_clear_instruction, hold_ports;
  logic [2:0] rc_div, irq_request, irq_enable;
  logic sys_osc_enable, wdog_osc_enable, cpu_clock_enable, chip_reset;
  logic warm_reset, resume_next, resume_irq, power_down_flag;
  logic watchdog_timeout_flag;
  int n_errors, n_compared, cycles, m_to, m_pdf;
  assign wdog_rc_clock = rc_div[2];
  hwrs_sequencer hwrs_sequencer_i (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .external_reset_pin_n,
    .first_port, .second_port, .third_port, .fourth_port, .wdog_rc_clock,
    .halt_instruction, .watchdog_clear_instruction, .irq_request,
    .irq_enable, .irq_master_enable, .stack_full, .sys_osc_enable,
    .wdog_osc_enable, .cpu_clock_enable, .chip_reset, .warm_reset,
    .hold_ports, .resume_next, .resume_irq, .power_down_flag,
    .watchdog_timeout_flag);
  hwrs_pin_model hwrs_pin_model_i (.clk, .external_reset_pin_n,
    .first_port, .second_port, .third_port, .fourth_port);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The watchdog oscillator only runs in the watchdog scenarios, so that
  // the long wake sequences before them are not cut short by an overflow.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rc_run) rc_div <= rc_div + 3'd1;
    if (cycles == 40000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_range(input int v, input int lo, input int hi,
                           input string what);
    n_compared++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("[ERR] %0t %s: %0d cycles", $time, what, v);
    end
  endtask
  task automatic chk_flags(input string what);
    chk({30'd0, watchdog_timeout_flag, power_down_flag},
        32'(m_to * 2 + m_pdf), what);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_range(n, 0, 19, "bus answer");
  endtask
  task automatic wait_cpu();
    int n;
    n = 0;
    while (cpu_clock_enable !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk_range(n, 0, 4999, "processor enable");
  endtask
  task automatic wait_rst(input logic warm);
    int n;
    n = 0;
    while ((warm ? warm_reset : chip_reset) !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk_range(n, 0, 3999, "watchdog overflow");
    m_to = 1;
  endtask
  task automatic wait_resume(input int t0, input logic vec);
    int n;
    n = 0;
    while (resume_next !== 1'b1 && resume_irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk({31'd0, resume_irq}, {31'd0, vec}, "resume kind");
    chk_range(cycles - t0, 1024, 1070, "wake delay");
    wait_cpu();
  endtask
  task automatic do_halt();
    @(posedge clk);
    halt_instruction <= 1'b1;
    @(posedge clk);
    halt_instruction <= 1'b0;
    m_pdf = 1;
    m_to = 0;
    repeat (3) @(posedge clk);
    chk({31'd0, hold_ports}, 32'd1, "frozen");
    chk({31'd0, sys_osc_enable}, 32'd0, "oscillator off");
    chk_flags("halt flags");
  endtask
  initial begin
    logic [31:0] q, cfg;
    logic err;
    int b, k;
    reset = 1'b1;
    {psel, penable, pwrite, rc_run, stack_full, irq_master_enable} = '0;
    {halt_instruction, watchdog_clear_instruction} = '0;
    {paddr, pwdata, rc_div, irq_request, irq_enable} = '0;
    b = $urandom(32'hd598aca4);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    k = cycles;
    wait_cpu();
    chk_range(cycles - k, 1024, 1040, "start-up delay");
    chk_flags("power-up flags");
    apb(1'b0, HWRS_OFS_CONFIG, 32'h0, q, err);
    chk(q, HWRS_CONFIG_RESET, "config reset value");
    apb(1'b0, 8'h0c, 32'h0, q, err);
    chk({31'd0, err}, 32'd1, "unmapped refused");
    apb(1'b1, HWRS_OFS_STATUS, 32'hffff_ffff, q, err);
    chk({31'd0, err}, 32'd1, "read-only refused");
    b = $urandom_range(7, 0);
    cfg = 32'h0000_3700 | (32'h1 << b);
    apb(1'b1, HWRS_OFS_CONFIG, cfg, q, err);
    apb(1'b0, HWRS_OFS_CONFIG, 32'h0, q, err);
    chk(q, cfg, "config readback");
    chk({31'd0, wdog_osc_enable}, 32'd1, "rc oscillator on");
    for (int i = 0; i < 4; i++) begin
      irq_request <= (i == 1) ? 3'b001 : 3'b000;
      do_halt();
      if (i < 2) begin
        hwrs_pin_model_i.port_fall(0, 8'(1 << ((b + 1) % 8)));
        repeat (40) @(posedge clk);
        chk({31'd0, hold_ports}, 32'd1, "no wake");
      end
      k = cycles;
      hwrs_pin_model_i.port_fall(i, 8'(1 << (i == 0 ? b : i + 3)));
      wait_resume(k, 1'b0);
      irq_request <= 3'b000;
    end
    for (int i = 0; i < 3; i++) begin
      irq_enable <= 3'b111;
      irq_master_enable <= (i != 1);
      stack_full <= (i == 2);
      do_halt();
      k = cycles;
      irq_request <= 3'(1 << $urandom_range(2, 0));
      wait_resume(k, (i == 0));
      irq_request <= 3'b000;
      irq_master_enable <= 1'b0;
    end
    rc_run <= 1'b1;
    wait_rst(1'b0);
    wait_cpu();
    chk_flags("run overflow flags");
    apb(1'b1, HWRS_OFS_CONFIG, cfg, q, err);
    do_halt();
    wait_rst(1'b1);
    chk({31'd0, chip_reset}, 32'd0, "warm only");
    wait_cpu();
    chk_flags("halt overflow flags");
    watchdog_clear_instruction <= 1'b1;
    rc_run <= 1'b0;
    @(posedge clk);
    watchdog_clear_instruction <= 1'b0;
    m_pdf = 0;
    m_to = 0;
    repeat (2) @(posedge clk);
    chk_flags("cleared flags");
    do_halt();
    hwrs_pin_model_i.pin_reset(10);
    m_pdf = 0;
    m_to = 0;
    wait_cpu();
    chk_flags("pin reset wake flags");
    finish_test();
  end
endmodule // hwrs_sequencer_tb
`default_nettype wire
